// ---- src/air_pkg.sv ----
// ==========================================================
// register map and field layout
package air_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_FLAG_CLR = 8'h1C;
  localparam logic [7:0] OFF_EN_SET = 8'h20;
  localparam logic [7:0] OFF_EN_CLR = 8'h24;
  localparam logic [7:0] OFF_MASK = 8'h28;
  localparam logic [7:0] OFF_RESULT = 8'h2C;
  localparam logic [7:0] OFF_CHANS = 8'h30;
  localparam logic [31:0] IRQ_BITS = 32'h0000_7333;
  localparam logic [31:0] EDGE_BITS = 32'h0000_7332;
  localparam int BIT_READY = 0;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_TOUCH = 4;
  localparam int BIT_LOST = 5;
  localparam int BIT_IDLE = 8;
  localparam int BIT_BUSY = 9;
  localparam int BIT_BELOW = 12;
  localparam int BIT_ABOVE = 13;
  localparam int BIT_INSIDE = 14;
  localparam int VALUE_W = 12;
  localparam int VALUE_LSB = 0;
  localparam int CHAN_W = 8;
  localparam int CHAN_LSB = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] CHANS_DEFAULT = 32'h0000_03FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/air_regs.sv ----
// Contract
// - edge-type pending flags latch on a zero-to-one step of live status
// - result-ready flag sets when a new result is stored
// - pending flag holds until software writes one to its clear bit
// - write-one flag-clear register clears flags; zeros ignored
// - write-one enable register sets mask bits; others unchanged
// - write-one disable register clears mask bits; others unchanged
// - read-only mask register shows enabled sources, resets to zero
// - result register also holds the source channel number
// - 12-bit result loads at each conversion end and holds
// - channel bit is one when the channel exists
// - live overrun bit reflects overrun since sequence start
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module air_regs import air_pkg::*; #(
  parameter logic [31:0] CHANNELS_PRESENT = CHANS_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] liveStatus,
  input wire logic convDone,
  input wire logic [VALUE_W-1:0] convValue,
  input wire logic [CHAN_W-1:0] convChannel,
  output logic irq
);
  // ==========================================================
  // helpers
  function automatic logic [7:0] word_off(input logic [AXI_AW-1:0] addr);
    return {addr[7:2], 2'b00};
  endfunction

  // ==========================================================
  // write channel
  logic awHeld, wHeld;
  logic [AXI_AW-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire [AXI_AW-1:0] next_awAddr = awTake ? s_axi_awaddr : awAddr;
  wire [31:0] next_wData = wTake ? s_axi_wdata : wData;
  wire [3:0] next_wStrb = wTake ? s_axi_wstrb : wStrb;
  wire next_awHeld = awHeld | awTake;
  wire next_wHeld = wHeld | wTake;
  wire doWrite = next_awHeld & next_wHeld & ~s_axi_bvalid;
  wire [31:0] strbMask = {{8{next_wStrb[3]}}, {8{next_wStrb[2]}},
                          {8{next_wStrb[1]}}, {8{next_wStrb[0]}}};
  wire [31:0] wBits = next_wData & strbMask & IRQ_BITS;
  wire [7:0] wOff = word_off(next_awAddr);
  wire wrClr = doWrite & (wOff == OFF_FLAG_CLR);
  wire wrSet = doWrite & (wOff == OFF_EN_SET);
  wire wrDis = doWrite & (wOff == OFF_EN_CLR);
  wire wrOk = wrClr | wrSet | wrDis;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= RESET_WORD;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      awHeld <= next_awHeld & ~doWrite;
      wHeld <= next_wHeld & ~doWrite;
      s_axi_awready <= ~next_awHeld & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~next_wHeld & ~s_axi_wready & ~s_axi_bvalid;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flags, mask and result
  logic [31:0] liveS1, liveS2, liveS3;
  logic doneS1, doneS2, doneS3;
  logic [31:0] flags, mask;
  logic [VALUE_W-1:0] resValue;
  logic [CHAN_W-1:0] resChan;
  logic [31:0] liveLvl;
  logic doneLvl;
  // a change counts once the second and third stages agree
  wire [31:0] liveAgree = ~(liveS2 ^ liveS3);
  wire [31:0] next_liveLvl = (liveS2 & liveAgree) | (liveLvl & ~liveAgree);
  wire doneAgree = ~(doneS2 ^ doneS3);
  wire next_doneLvl = doneAgree ? doneS2 : doneLvl;
  wire [31:0] liveRise = next_liveLvl & ~liveLvl & EDGE_BITS;
  wire newResult = next_doneLvl & ~doneLvl;
  wire [31:0] setBits = liveRise | ({31'h0, newResult} << BIT_READY);
  wire [31:0] clrBits = wrClr ? wBits : 32'h0;
  wire [31:0] next_flags = (flags & ~clrBits) | setBits;
  wire [31:0] next_mask = (mask | (wrSet ? wBits : 32'h0))
                          & ~(wrDis ? wBits : 32'h0);
  wire next_irq = |(next_flags & next_mask);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      liveS1 <= RESET_WORD;
      liveS2 <= RESET_WORD;
      liveS3 <= RESET_WORD;
      doneS1 <= 1'b0;
      doneS2 <= 1'b0;
      doneS3 <= 1'b0;
      liveLvl <= RESET_WORD;
      doneLvl <= 1'b0;
      flags <= RESET_WORD;
      mask <= RESET_WORD;
      irq <= 1'b0;
      resValue <= '0;
      resChan <= '0;
    end else begin
      liveS1 <= liveStatus;
      liveS2 <= liveS1;
      liveS3 <= liveS2;
      doneS1 <= convDone;
      doneS2 <= doneS1;
      doneS3 <= doneS2;
      liveLvl <= next_liveLvl;
      doneLvl <= next_doneLvl;
      flags <= next_flags;
      mask <= next_mask;
      irq <= next_irq;
      if (newResult) begin
        resValue <= convValue;
        resChan <= convChannel;
      end
    end
  end

  // ==========================================================
  // read channel
  wire [7:0] rOff = word_off(s_axi_araddr);
  wire [31:0] resultWord = ({{(32-CHAN_W){1'b0}}, resChan} << CHAN_LSB)
                         | ({{(32-VALUE_W){1'b0}}, resValue} << VALUE_LSB);
  wire rdHit = (rOff == OFF_FLAGS) | (rOff == OFF_MASK)
             | (rOff == OFF_RESULT) | (rOff == OFF_CHANS)
             | (rOff == OFF_FLAG_CLR) | (rOff == OFF_EN_SET)
             | (rOff == OFF_EN_CLR);
  wire [31:0] rdWord =
      (rOff == OFF_FLAGS) ? flags :
      (rOff == OFF_MASK) ? mask :
      (rOff == OFF_RESULT) ? resultWord :
      (rOff == OFF_CHANS) ? CHANNELS_PRESENT : RESET_WORD;
  wire rdTake = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RESET_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rdTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  a_rise_sets_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    |liveRise |=> |(flags & $past(liveRise)))
    else $error("live rise did not set flag");
  a_done_sets_ready: assert property (@(posedge ref_clk) disable iff (!arst_n)
    newResult |=> flags[BIT_READY])
    else $error("result ready flag not set");
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (flags[BIT_OVERRUN] && !(wrClr && wBits[BIT_OVERRUN]))
    |=> flags[BIT_OVERRUN])
    else $error("flag dropped without clear");
  a_clear_works: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrClr && wBits[BIT_TOUCH] && !liveRise[BIT_TOUCH])
    |=> !flags[BIT_TOUCH])
    else $error("clear write ignored");
  a_enable_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrSet && wBits[BIT_BUSY]) |=> mask[BIT_BUSY])
    else $error("enable write ignored");
  a_disable_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrDis && wBits[BIT_BUSY]) |=> !mask[BIT_BUSY])
    else $error("disable write ignored");
  a_mask_stable: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(wrSet || wrDis) |=> $stable(mask))
    else $error("mask changed without write");
  a_result_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !newResult |=> ($stable(resValue) && $stable(resChan)))
    else $error("result changed without conversion");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 irq == |($past(next_flags) & $past(next_mask)))
    else $error("interrupt level wrong");

  a_touch_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
    liveRise[BIT_TOUCH] |=> flags[BIT_TOUCH])
    else $error("touch flag not set");

  a_overrun_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
    liveRise[BIT_OVERRUN] |=> flags[BIT_OVERRUN])
    else $error("overrun flag not set");

  a_flags_layout: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (flags & ~IRQ_BITS) == 32'h0)
    else $error("flag outside layout");

  a_mask_layout: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (mask & ~IRQ_BITS) == 32'h0)
    else $error("mask bit outside layout");

  a_clear_zero_keeps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrClr && !wBits[BIT_BUSY] && flags[BIT_BUSY]) |=> flags[BIT_BUSY])
    else $error("zero clear bit dropped flag");

  a_enable_keeps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrSet && !wBits[BIT_TOUCH]) |=> mask[BIT_TOUCH] == $past(mask[BIT_TOUCH]))
    else $error("enable write touched other bit");

  a_disable_keeps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wrDis && !wBits[BIT_TOUCH]) |=> mask[BIT_TOUCH] == $past(mask[BIT_TOUCH]))
    else $error("disable write touched other bit");

  a_result_loads: assert property (@(posedge ref_clk) disable iff (!arst_n)
    newResult |=> resValue == $past(convValue))
    else $error("result value not loaded");

  a_chan_loads: assert property (@(posedge ref_clk) disable iff (!arst_n)
    newResult |=> resChan == $past(convChannel))
    else $error("result channel not loaded");

  a_irq_matches: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq == |(flags & mask))
    else $error("interrupt does not match flags and mask");

  a_bvalid_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");

  a_rvalid_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped early");

  a_awready_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");

  a_wready_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_axi_wready |=> !s_axi_wready)
    else $error("data ready held");

  a_arready_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");

  a_ro_write_err: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (doWrite && !wrOk) |=> s_axi_bresp == RESP_SLVERR)
    else $error("read-only write not refused");

  a_chans_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rdTake && rOff == OFF_CHANS) |=> s_axi_rdata == CHANNELS_PRESENT)
    else $error("channel register wrong");

  a_mask_reads: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rdTake && rOff == OFF_MASK) |=> s_axi_rdata == $past(mask))
    else $error("mask read wrong");

  a_flags_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rdTake && rOff == OFF_FLAGS) |=> s_axi_rdata == $past(flags))
    else $error("flag read wrong");

  a_result_reads: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rdTake && rOff == OFF_RESULT)
    |=> s_axi_rdata[CHAN_LSB +: CHAN_W] == $past(resChan))
    else $error("result channel read wrong");
endmodule
`default_nettype wire

// ---- tb/air_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module air_regs_tb import air_pkg::*;;
  // ==========================================================
  // signals
  logic ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, convDone, irq;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, liveStatus, m, c, f;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [VALUE_W-1:0] convValue;
  logic [CHAN_W-1:0] convChannel;
  logic [33:0] expQ[$];
  int miscompares, tests_run, waitN;
  air_regs i_dut (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .liveStatus, .convDone, .convValue, .convChannel, .irq);
  // ==========================================================
  // bus tasks
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    waitN++;
    if (waitN > 60) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    waitN = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      tick();
      if (s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do tick(); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    waitN = 0;
    expQ.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do tick(); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // ==========================================================
  // read monitor
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (expQ.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        `CHK({s_axi_rresp, s_axi_rdata}, expQ.pop_front())
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // tests
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, convDone, liveStatus} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, convValue, convChannel} = '0;
    s_axi_wstrb = 4'hF;
    m = $urandom(32'hE5067A73);
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFF_MASK, {RESP_OKAY, RESET_WORD});
    rd(OFF_FLAGS, {RESP_OKAY, RESET_WORD});
    rd(OFF_RESULT, {RESP_OKAY, RESET_WORD});
    rd(OFF_CHANS, {RESP_OKAY, CHANS_DEFAULT});
    rd(8'h3C, {RESP_SLVERR, 32'h0000_0000});
    rd(OFF_FLAG_CLR, {RESP_OKAY, 32'h0000_0000});
    wr(OFF_MASK, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test reset done");
    m = $urandom & IRQ_BITS;
    c = $urandom;
    wr(OFF_EN_SET, m, RESP_OKAY);
    rd(OFF_MASK, {RESP_OKAY, m});
    wr(OFF_EN_CLR, c, RESP_OKAY);
    rd(OFF_MASK, {RESP_OKAY, m & ~c});
    wr(OFF_EN_SET, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_MASK, {RESP_OKAY, IRQ_BITS});
    $display("test mask done");
    liveStatus <= 32'hFFFF_FFFF;
    repeat (8) @(posedge ref_clk);
    rd(OFF_FLAGS, {RESP_OKAY, EDGE_BITS});
    `CHK(irq, 1'b1)
    c = $urandom & IRQ_BITS;
    wr(OFF_FLAG_CLR, c, RESP_OKAY);
    rd(OFF_FLAGS, {RESP_OKAY, EDGE_BITS & ~c});
    wr(OFF_EN_CLR, 32'hFFFF_FFFF, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(OFF_FLAG_CLR, 32'hFFFF_FFFF, RESP_OKAY);
    $display("test flags done");
    repeat (3) begin
      convValue <= VALUE_W'($urandom);
      convChannel <= CHAN_W'($urandom);
      convDone <= 1'b1;
      repeat (2) @(posedge ref_clk);
      convDone <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(OFF_RESULT, {RESP_OKAY, 8'h00, convChannel, 4'h0, convValue});
    end
    rd(OFF_FLAGS, {RESP_OKAY, 32'h0000_0001});
    wr(OFF_EN_SET, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(OFF_FLAG_CLR, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    s_axi_wstrb <= 4'h2;
    wr(OFF_EN_CLR, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_MASK, {RESP_OKAY, 32'h0000_0001});
    s_axi_wstrb <= 4'h1;
    wr(OFF_EN_CLR, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_MASK, {RESP_OKAY, 32'h0000_0000});
    $display("test result done");
    complete_run();
  end
endmodule
`default_nettype wire
